// ==== rtl/fmcw_pkg.sv ====
// Constants shared by the ramp and modulation engine
package fmcw_pkg;
  // ------------------------------------------------------------
  // Register word indexes
  // ------------------------------------------------------------
  localparam logic [3:0] REG_FRAC_INT = 4'h0;
  localparam logic [3:0] REG_LSB_FRAC = 4'h1;
  localparam logic [3:0] REG_RDIV = 4'h2;
  localparam logic [3:0] REG_FUNC = 4'h3;
  localparam logic [3:0] REG_CLOCK = 4'h4;
  localparam logic [3:0] REG_DEV = 4'h5;
  localparam logic [3:0] REG_STEP = 4'h6;
  localparam logic [3:0] REG_DELAY = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int F_FRAC_LO = 3;   // 12-bit upper fraction, R0
  localparam int F_INT_LO = 15;   // 12-bit integer, R0
  localparam int F_START = 31;    // Ramp start, R0
  localparam int F_LSB_LO = 15;   // 13-bit lower fraction, R1
  localparam int F_PHASE_LO = 3;  // 12-bit phase, R1
  localparam int F_FIRST_TIMER_DIVIDER_LO = 3;   // 12-bit first timer, R2
  localparam int F_RDIV_LO = 15;  // 5-bit R divider, R2
  localparam int F_DBL = 20;
  localparam int F_HALF = 21;
  localparam int F_CSR = 28;
  localparam int F_FSK_EN = 8;    // R3
  localparam int F_PSK_EN = 9;    // R3
  localparam int F_RAMP_LO = 10;  // 2-bit ramp type, R3
  localparam int F_CLKSEL = 6;    // R4
  localparam int F_SECOND_TIMER_DIVIDER_LO = 7;   // R4
  localparam int F_DIVMODE_LO = 19; // R4
  localparam int F_DEV_LO = 3;    // R5
  localparam int F_SHIFT_LO = 19; // R5
  localparam int F_SEL = 23;      // R5, R6
  localparam int F_INV = 30;      // R5
  localparam int F_STEPW_LO = 3;  // R6
  localparam int F_FULL_TRI = 21; // R7
  localparam logic [1:0] DIVMODE_RAMP = 2'h3;
  localparam logic [2:0] CELLS_MAX = 3'h7;
  // ------------------------------------------------------------
  // Ramp types and states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    RT_CONT_SAW = 2'h0,
    RT_CONT_TRI = 2'h1,
    RT_SINGLE_SAW = 2'h2,
    RT_SINGLE_RAMP = 2'h3
  } fmcw_rtype_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_UP = 2'h1,
    ST_DOWN = 2'h2,
    ST_HOLD = 2'h3
  } fmcw_state_e;
endpackage

// ==== rtl/fmcw_ramp_engine.sv ====
// Divide-word, modulation, ramp and slip-reduction engine
//
// Notes on behaviour
// - Divide value is integer plus fraction over two to the 25.
// - Fraction is upper 12 bits times 8192 plus lower 13 bits.
// - PFD rate uses doubler, halver and R divider of 1 to 32.
// - Doubler enable doubles the reference ahead of the R divider.
// - Slip reduction works only with its enable bit set.
// - Each impending slip turns on one more extra current cell.
// - At most seven cells; after overshoot they go off one by one.
// - Step is deviation word shifted left by the shift field.
// - FSK hops the centre divide value up or down by the step.
// - PSK phase is the 12-bit phase value in 4096ths of a turn.
// - PSK: pin high advances, pin low retards by the phase value.
// - Five waveforms: ramp, triangle, sawtooth bursts, two continuous.
// - Hop interval is first times second timer PFD periods.
// - Hop count comes from the 20-bit step word.
// - Single ramp adds the step each interval, then holds.
// - Single triangle subtracts the step after the upward part.
// - Invert bit picks rising or falling modulation pin edge.
// - Continuous triangle alternates up and down until disabled.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module fmcw_ramp_engine #(
  parameter int INT_W = 12,
  parameter int FRAC_W = 25,
  parameter int STEP_W = 20
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic modulation_input_pin,
  input wire logic slip_pending,
  input wire logic slip_dir_up,
  input wire logic freq_passed,
  output logic [INT_W-1:0] n_int_out,
  output logic [FRAC_W-1:0] n_frac_out,
  output logic [11:0] phase_out,
  output logic [5:0] ref_div_out,
  output logic ref_double_en,
  output logic ref_halve_en,
  output logic [2:0] slip_cells,
  output logic slip_source,
  output logic ramp_busy
);
  localparam int ACC_W = INT_W + FRAC_W;

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [31:0] r0_ff, r1_ff, r2_ff, r3_ff, r7_ff;
  logic [31:0] r4_ff [2];
  logic [31:0] r5_ff [2];
  logic [31:0] r6_ff [2];
  logic [31:0] rdata_ff;
  wire wr_sel = reg_wdata[fmcw_pkg::F_SEL];
  wire clk_sel = reg_wdata[fmcw_pkg::F_CLKSEL];
  wire start_wr = reg_wr && reg_addr == fmcw_pkg::REG_FRAC_INT;

  // Paired registers keep one copy per select value
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r0_ff <= fmcw_pkg::REG_RESET;
      r1_ff <= fmcw_pkg::REG_RESET;
      r2_ff <= fmcw_pkg::REG_RESET;
      r3_ff <= fmcw_pkg::REG_RESET;
      r7_ff <= fmcw_pkg::REG_RESET;
      r4_ff <= '{default: fmcw_pkg::REG_RESET};
      r5_ff <= '{default: fmcw_pkg::REG_RESET};
      r6_ff <= '{default: fmcw_pkg::REG_RESET};
    end else if (reg_wr) begin
      case (reg_addr)
        fmcw_pkg::REG_FRAC_INT: r0_ff <= reg_wdata;
        fmcw_pkg::REG_LSB_FRAC: r1_ff <= reg_wdata;
        fmcw_pkg::REG_RDIV: r2_ff <= reg_wdata;
        fmcw_pkg::REG_FUNC: r3_ff <= reg_wdata;
        fmcw_pkg::REG_CLOCK: r4_ff[clk_sel] <= reg_wdata;
        fmcw_pkg::REG_DEV: r5_ff[wr_sel] <= reg_wdata;
        fmcw_pkg::REG_STEP: r6_ff[wr_sel] <= reg_wdata;
        fmcw_pkg::REG_DELAY: r7_ff <= reg_wdata;
        default: r7_ff <= r7_ff;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  wire [INT_W-1:0] int_w = INT_W'(r0_ff[fmcw_pkg::F_INT_LO +: 12]);
  wire [11:0] frac_hi = r0_ff[fmcw_pkg::F_FRAC_LO +: 12];
  wire [12:0] frac_lo = r1_ff[fmcw_pkg::F_LSB_LO +: 13];
  // Upper times 8192 plus lower is plain concatenation
  wire [ACC_W-1:0] centre_w = {int_w, frac_hi, frac_lo};
  wire [11:0] phase_w = r1_ff[fmcw_pkg::F_PHASE_LO +: 12];
  wire [11:0] first_timer_divider_w = r2_ff[fmcw_pkg::F_FIRST_TIMER_DIVIDER_LO +: 12];
  wire [4:0] rdiv_w = r2_ff[fmcw_pkg::F_RDIV_LO +: 5];
  wire csr_en = r2_ff[fmcw_pkg::F_CSR];
  wire fsk_en = r3_ff[fmcw_pkg::F_FSK_EN];
  wire psk_en = r3_ff[fmcw_pkg::F_PSK_EN];
  wire [1:0] rtype = r3_ff[fmcw_pkg::F_RAMP_LO +: 2];
  wire [11:0] second_timer_divider_w = r4_ff[0][fmcw_pkg::F_SECOND_TIMER_DIVIDER_LO +: 12];
  wire ramp_div = r4_ff[0][fmcw_pkg::F_DIVMODE_LO +: 2]
                  == fmcw_pkg::DIVMODE_RAMP;
  wire inv_edge = r5_ff[0][fmcw_pkg::F_INV];
  wire full_tri = r7_ff[fmcw_pkg::F_FULL_TRI];
  wire [STEP_W-1:0] steps_w = r6_ff[0][fmcw_pkg::F_STEPW_LO +: STEP_W];

  // Reference path settings; a zero R field stands for 32
  assign ref_div_out = (rdiv_w == 5'h00) ? 6'h20 : {1'b0, rdiv_w};
  assign ref_double_en = r2_ff[fmcw_pkg::F_DBL];
  assign ref_halve_en = r2_ff[fmcw_pkg::F_HALF];

  // ------------------------------------------------------------
  // Deviation steps, word 0 ramps and word 1 keys
  // ------------------------------------------------------------
  logic signed [ACC_W-1:0] ramp_step, fsk_step;
  always_comb begin
    ramp_step = ACC_W'($signed(r5_ff[0][fmcw_pkg::F_DEV_LO +: 16]))
                <<< r5_ff[0][fmcw_pkg::F_SHIFT_LO +: 4];
    fsk_step = ACC_W'($signed(r5_ff[1][fmcw_pkg::F_DEV_LO +: 16]))
               <<< r5_ff[1][fmcw_pkg::F_SHIFT_LO +: 4];
  end

  // ------------------------------------------------------------
  // Modulation pin edge detect
  // ------------------------------------------------------------
  logic pin_d_ff, fsk_hi_ff;
  wire pin_rise = modulation_input_pin && !pin_d_ff;
  wire pin_fall = !modulation_input_pin && pin_d_ff;
  wire pin_evt = inv_edge ? pin_fall : pin_rise;

  // Each active edge swaps the FSK side of centre
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_d_ff <= 1'b0;
      fsk_hi_ff <= 1'b0;
    end else begin
      pin_d_ff <= modulation_input_pin;
      if (!fsk_en) fsk_hi_ff <= 1'b0;
      else if (pin_evt) fsk_hi_ff <= !fsk_hi_ff;
    end
  end

  // ------------------------------------------------------------
  // Hop interval timer: two cascaded dividers
  // ------------------------------------------------------------
  logic [11:0] t1_ff, t2_ff;
  fmcw_pkg::fmcw_state_e state_ff, nxt_state;
  wire timing = state_ff == fmcw_pkg::ST_UP ||
                state_ff == fmcw_pkg::ST_DOWN;
  // A zero divider acts as one so the timer can never stall
  wire t1_end = {1'b0, t1_ff} + 13'h0001 >= {1'b0, first_timer_divider_w};
  wire t2_end = {1'b0, t2_ff} + 13'h0001 >= {1'b0, second_timer_divider_w};
  wire tick = timing && ramp_div && t1_end && t2_end;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      t1_ff <= 12'h000;
      t2_ff <= 12'h000;
    end else if (!timing || !ramp_div) begin
      t1_ff <= 12'h000;
      t2_ff <= 12'h000;
    end else if (t1_end) begin
      t1_ff <= 12'h000;
      t2_ff <= t2_end ? 12'h000 : t2_ff + 12'h001;
    end else begin
      t1_ff <= t1_ff + 12'h001;
    end
  end

  // ------------------------------------------------------------
  // Ramp state machine and divide accumulator
  // ------------------------------------------------------------
  logic [ACC_W-1:0] acc_ff, nxt_acc;
  logic [STEP_W-1:0] cnt_ff, nxt_cnt;
  wire start_set = start_wr && reg_wdata[fmcw_pkg::F_START];
  wire start_clr = start_wr && !reg_wdata[fmcw_pkg::F_START];
  wire cnt_done = cnt_ff == steps_w;
  wire is_tri = rtype == fmcw_pkg::RT_CONT_TRI || full_tri;

  // End-of-leg action depends on the waveform type
  always_comb begin
    nxt_state = state_ff;
    nxt_acc = acc_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      fmcw_pkg::ST_IDLE: begin
        nxt_acc = centre_w;
        nxt_cnt = '0;
        if (start_set) nxt_state = fmcw_pkg::ST_UP;
      end
      fmcw_pkg::ST_UP: begin
        if (tick && !cnt_done) begin
          nxt_acc = acc_ff + ramp_step;
          nxt_cnt = cnt_ff + 1'b1;
        end else if (tick && is_tri) begin
          nxt_acc = acc_ff - ramp_step;
          nxt_cnt = STEP_W'(1);
          nxt_state = fmcw_pkg::ST_DOWN;
        end else if (tick && rtype == fmcw_pkg::RT_SINGLE_RAMP) begin
          nxt_state = fmcw_pkg::ST_HOLD;
        end else if (tick) begin
          // Sawtooth returns to centre one interval after the last hop
          nxt_acc = centre_w;
          nxt_cnt = '0;
          if (rtype == fmcw_pkg::RT_SINGLE_SAW) nxt_state = fmcw_pkg::ST_HOLD;
        end
      end
      fmcw_pkg::ST_DOWN: begin
        if (tick && !cnt_done) begin
          nxt_acc = acc_ff - ramp_step;
          nxt_cnt = cnt_ff + 1'b1;
        end else if (tick && rtype == fmcw_pkg::RT_CONT_TRI) begin
          nxt_acc = acc_ff + ramp_step;
          nxt_cnt = STEP_W'(1);
          nxt_state = fmcw_pkg::ST_UP;
        end else if (tick) begin
          nxt_state = fmcw_pkg::ST_HOLD;
        end
      end
      fmcw_pkg::ST_HOLD: nxt_acc = acc_ff;
      default: nxt_state = fmcw_pkg::ST_IDLE;
    endcase
    // Clearing the start bit disables any ramp
    if (start_clr) nxt_state = fmcw_pkg::ST_IDLE;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= fmcw_pkg::ST_IDLE;
      acc_ff <= '0;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      acc_ff <= nxt_acc;
      cnt_ff <= nxt_cnt;
    end
  end
  assign ramp_busy = timing;

  // ------------------------------------------------------------
  // Output divide word and PSK phase, registered
  // ------------------------------------------------------------
  logic [ACC_W-1:0] nout_ff;
  logic [11:0] phase_ff;
  wire [ACC_W-1:0] fsk_off = fsk_hi_ff ? fsk_step : -fsk_step;
  wire [ACC_W-1:0] nout_w = fsk_en ? acc_ff + fsk_off : acc_ff;
  wire [11:0] psk_w = modulation_input_pin ? phase_w : -phase_w;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nout_ff <= '0;
      phase_ff <= 12'h000;
    end else begin
      nout_ff <= nout_w;
      phase_ff <= psk_en ? psk_w : 12'h000;
    end
  end
  assign n_int_out = nout_ff[ACC_W-1 -: INT_W];
  assign n_frac_out = nout_ff[FRAC_W-1:0];
  assign phase_out = phase_ff;

  // ------------------------------------------------------------
  // Slip reduction cell sequencer
  // ------------------------------------------------------------
  logic [2:0] cells_ff;
  logic passed_ff, dir_ff;
  wire cell_add = csr_en && slip_pending && !passed_ff &&
                  cells_ff != fmcw_pkg::CELLS_MAX;
  wire cell_drop = csr_en && passed_ff && cells_ff != 3'h0;

  // Overshoot latches until the last cell is off
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cells_ff <= 3'h0;
      passed_ff <= 1'b0;
      dir_ff <= 1'b0;
    end else if (!csr_en) begin
      cells_ff <= 3'h0;
      passed_ff <= 1'b0;
    end else begin
      if (cell_add) cells_ff <= cells_ff + 3'h1;
      else if (cell_drop) cells_ff <= cells_ff - 3'h1;
      if (cell_add) dir_ff <= slip_dir_up;
      if (freq_passed && cells_ff != 3'h0) passed_ff <= 1'b1;
      else if (cells_ff == 3'h0) passed_ff <= 1'b0;
    end
  end
  assign slip_cells = cells_ff;
  assign slip_source = dir_ff;

  // ------------------------------------------------------------
  // Register readback, one cycle after the read strobe
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      fmcw_pkg::REG_FRAC_INT: rd_mux = r0_ff;
      fmcw_pkg::REG_LSB_FRAC: rd_mux = r1_ff;
      fmcw_pkg::REG_RDIV: rd_mux = r2_ff;
      fmcw_pkg::REG_FUNC: rd_mux = r3_ff;
      fmcw_pkg::REG_CLOCK: rd_mux = r4_ff[0];
      fmcw_pkg::REG_DEV: rd_mux = r5_ff[0];
      fmcw_pkg::REG_STEP: rd_mux = r6_ff[0];
      fmcw_pkg::REG_DELAY: rd_mux = r7_ff;
      fmcw_pkg::REG_STATUS:
        rd_mux = {state_ff, cells_ff, passed_ff, fsk_hi_ff, 5'h00, cnt_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rdata_ff <= 32'h0000_0000;
    else rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
  end
  assign reg_rdata = rdata_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_idle2;
    state_ff == fmcw_pkg::ST_IDLE ##1 state_ff == fmcw_pkg::ST_IDLE;
  endsequence
  sequence s_up_hop;
    tick && state_ff == fmcw_pkg::ST_UP && !cnt_done && !start_clr;
  endsequence

  a_centre_compose: assert property (
    s_idle2 |-> acc_ff == {$past(int_w), $past(frac_hi), $past(frac_lo)})
    else $error("accumulator not at composed centre");
  a_csr_gate: assert property (!csr_en |=> cells_ff == 3'h0)
    else $error("cells active with slip reduction off");
  a_cell_add: assert property (
    cell_add |=> cells_ff == $past(cells_ff) + 3'h1)
    else $error("impending slip did not add a cell");
  a_cell_drop: assert property (
    cell_drop && csr_en ##1 csr_en |-> cells_ff == $past(cells_ff) - 3'h1)
    else $error("cells not released one by one");
  a_ramp_up_hop: assert property (
    s_up_hop |=> acc_ff == $past(acc_ff) + $past(ramp_step))
    else $error("upward hop wrong");
  a_ramp_down_hop: assert property (
    tick && state_ff == fmcw_pkg::ST_DOWN && !cnt_done && !start_clr
    |=> acc_ff == $past(acc_ff) - $past(ramp_step))
    else $error("downward hop wrong");
  a_acc_between: assert property (
    timing && !tick && !start_clr |=> $stable(acc_ff))
    else $error("accumulator moved between intervals");
  a_psk_phase: assert property (
    psk_en |=> phase_out == ($past(modulation_input_pin) ?
      $past(phase_w) : 12'(-$past(phase_w))))
    else $error("psk phase wrong");
  a_fsk_edge: assert property (
    fsk_en && pin_evt |=> fsk_hi_ff != $past(fsk_hi_ff))
    else $error("fsk side did not swap on active edge");
endmodule

// ==== test/fmcw_host_model.sv ====
// Host controller model that programs the engine over its register port
`timescale 1ns/1ps
module fmcw_host_model (
  input wire logic core_clk,
  output logic [3:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // Bus idles with both strobes low
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  // Data is inverted once the strobe drops, so stale data never helps
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Read data taken in the cycle after the strobe, then one cycle later
  task automatic rd(input logic [3:0] a, output logic [31:0] q,
    output logic [31:0] q_late);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge core_clk);
    #1 q_late = reg_rdata;
  endtask
  // ------------------------------------------------------------
  // Programming sequences
  // ------------------------------------------------------------
  // Power-up order; step, deviation and clock go in copy 0 then copy 1
  task automatic init(input logic [31:0] r7, r6, r5a, r5b, r4, r3, r2,
    r1, r0);
    logic [31:0] f;
    f = r3;
    if (r2[28]) f[6] = 1'b1;
    wr(fmcw_pkg::REG_DELAY, r7);
    wr(fmcw_pkg::REG_STEP, r6 & 32'hFF7F_FFFF);
    wr(fmcw_pkg::REG_STEP, r6 | 32'h0080_0000);
    wr(fmcw_pkg::REG_DEV, r5a & 32'hFF7F_FFFF);
    wr(fmcw_pkg::REG_DEV, r5b | 32'h0080_0000);
    wr(fmcw_pkg::REG_CLOCK, r4 & 32'hFFFF_FFBF);
    wr(fmcw_pkg::REG_CLOCK, r4 | 32'h0000_0040);
    wr(fmcw_pkg::REG_FUNC, f);
    wr(fmcw_pkg::REG_RDIV, r2);
    wr(fmcw_pkg::REG_LSB_FRAC, r1);
    wr(fmcw_pkg::REG_FRAC_INT, r0);
  endtask
  // Stop first, since a start while running is ignored
  task automatic start(input logic [31:0] r3, input logic [31:0] r0);
    wr(fmcw_pkg::REG_FRAC_INT, r0 & 32'h7FFF_FFFF);
    wr(fmcw_pkg::REG_FUNC, r3);
    wr(fmcw_pkg::REG_FRAC_INT, r0 | 32'h8000_0000);
  endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the ramp and modulation engine
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  error_cnt++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module testbench;
  logic core_clk = 1'b0;
  logic reset_n;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic modulation_input_pin;
  logic slip_pending;
  logic slip_dir_up;
  logic freq_passed;
  logic [11:0] n_int_out;
  logic [24:0] n_frac_out;
  logic [11:0] phase_out;
  logic [5:0] ref_div_out;
  logic ref_double_en;
  logic ref_halve_en;
  logic [2:0] slip_cells;
  logic slip_source;
  logic ramp_busy;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] q;
  logic [31:0] ql;
  wire logic [37:0] nval = {1'b0, n_int_out, n_frac_out};
  // Reference settings packed as divider, doubler, halver
  wire logic [7:0] ref_all = {ref_div_out, ref_double_en, ref_halve_en};
  // First timer 2 and second timer 3 give a six-cycle hop interval
  localparam logic [31:0] R2_BASE = 32'h0000_8010;
  localparam logic [31:0] R4_RAMP = 32'h0018_0180;
  localparam logic [31:0] R5_RAMP = 32'h0078_2000;
  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  fmcw_host_model host (.core_clk, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata);
  fmcw_ramp_engine dut (.core_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .modulation_input_pin, .slip_pending,
    .slip_dir_up, .freq_passed, .n_int_out, .n_frac_out, .phase_out,
    .ref_div_out, .ref_double_en, .ref_halve_en, .slip_cells,
    .slip_source, .ramp_busy);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] r0w(input logic [11:0] i,
    input logic [11:0] f);
    return {5'h00, i, f, 3'h0};
  endfunction
  task automatic settle;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic set_pin(input logic v);
    @(posedge core_clk);
    modulation_input_pin <= v;
    settle;
  endtask
  task automatic pulse_slip(input int n, input logic up);
    @(posedge core_clk);
    slip_pending <= 1'b1;
    slip_dir_up <= up;
    repeat (n) @(posedge core_clk);
    slip_pending <= 1'b0;
    settle;
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_init;
    host.init(32'h0, 32'h0000_0018, R5_RAMP, 32'h0078_4000, R4_RAMP,
      32'h0, R2_BASE, 32'h0EB8_0000, r0w(12'd121, 12'd81));
    settle;
    `CHK("int", 12'd121, n_int_out)
    `CHK("frac", 25'h00A_3D70, n_frac_out)
    host.rd(fmcw_pkg::REG_LSB_FRAC, q, ql);
    `CHK("rd r1", 32'h0EB8_0000, q)
    `CHK("rd late", 32'h0, ql)
    host.rd(4'h9, q, ql);
    `CHK("rd unmapped", 32'h0, q)
  endtask
  task automatic t_ref;
    logic [31:0] w [3] = '{32'h0, 32'h0012_8000, 32'h002F_8000};
    logic [7:0] e [3] = '{8'h80, 8'h16, 8'h7D};
    for (int i = 0; i < 3; i++) begin
      host.wr(fmcw_pkg::REG_RDIV, w[i]);
      settle;
      `CHK("ref", e[i], ref_all)
    end
    host.wr(fmcw_pkg::REG_RDIV, R2_BASE);
  endtask
  task automatic t_slip;
    logic [2:0] prev;
    pulse_slip(1, 1'b0);
    `CHK("cells off", 3'h0, slip_cells)
    host.wr(fmcw_pkg::REG_FUNC, 32'h0000_0040);
    host.wr(fmcw_pkg::REG_RDIV, R2_BASE | 32'h1000_0000);
    pulse_slip(1, 1'b0);
    `CHK("cells one", 4'h2, {slip_cells, slip_source})
    pulse_slip(9, 1'b1);
    `CHK("cells max", 4'hF, {slip_cells, slip_source})
    @(posedge core_clk);
    freq_passed <= 1'b1;
    @(posedge core_clk);
    freq_passed <= 1'b0;
    prev = 3'h7;
    for (int i = 0; i < 20 && prev != 3'h0; i++) begin
      #1;
      if (slip_cells !== prev) begin
        `CHK("cells down", prev - 3'h1, slip_cells)
        prev = slip_cells;
      end
      @(posedge core_clk);
    end
    `CHK("cells zero", 3'h0, slip_cells)
    host.wr(fmcw_pkg::REG_RDIV, R2_BASE);
  endtask
  task automatic t_psk;
    host.wr(fmcw_pkg::REG_LSB_FRAC, 32'h0000_2000);
    host.wr(fmcw_pkg::REG_FUNC, 32'h0000_0240);
    set_pin(1'b1);
    `CHK("psk high", 12'h400, phase_out)
    set_pin(1'b0);
    `CHK("psk low", 12'hC00, phase_out)
    host.wr(fmcw_pkg::REG_LSB_FRAC, 32'h0000_6000);
    settle;
    `CHK("psk negated", 12'h400, phase_out)
  endtask
  // FSK uses deviation copy 1: two integers either side of 100
  task automatic t_fsk;
    logic [37:0] v0;
    logic [37:0] v1;
    logic [37:0] dv;
    host.wr(fmcw_pkg::REG_FRAC_INT, r0w(12'd100, 12'd0));
    host.wr(fmcw_pkg::REG_FUNC, 32'h0000_0140);
    settle;
    v0 = nval;
    set_pin(1'b1);
    v1 = nval;
    `CHK("fsk centre", 38'h01_9000_0000, v0 + v1)
    dv = (v1 > v0) ? v1 - v0 : v0 - v1;
    `CHK("fsk span", 38'h00_0800_0000, dv)
    set_pin(1'b0);
    `CHK("fsk fall", v1, nval)
    host.wr(fmcw_pkg::REG_DEV, R5_RAMP | 32'h4000_0000);
    set_pin(1'b1);
    `CHK("fsk inv rise", v1, nval)
    set_pin(1'b0);
    `CHK("fsk inv fall", v0, nval)
    host.wr(fmcw_pkg::REG_DEV, R5_RAMP);
  endtask
  // One ramp run: each hop value, six-cycle gaps, then hold or run on
  task automatic t_ramp(input logic [1:0] t, input logic tri_on,
    input int n, input int seq [7], input logic busy_end);
    logic [11:0] last;
    int gap;
    host.wr(fmcw_pkg::REG_DELAY, tri_on ? 32'h0020_0000 : 32'h0);
    host.start({20'h0, t, 10'h040}, r0w(12'd100, 12'd0));
    settle;
    `CHK("ramp base", 12'd100, n_int_out)
    last = n_int_out;
    for (int i = 0; i < n; i++) begin
      gap = 0;
      while (n_int_out === last && gap < 40) begin
        @(posedge core_clk);
        #1 gap++;
      end
      if (gap == 40) begin
        error_cnt++;
        print_verdict;
      end
      `CHK("hop value", 12'(100 + seq[i]), n_int_out)
      if (i > 0) `CHK("hop gap", 6, gap)
      last = n_int_out;
    end
    // Status is read only once the last interval has closed the leg
    repeat (20) @(posedge core_clk);
    #1 `CHK("busy", busy_end, ramp_busy)
    host.rd(fmcw_pkg::REG_STATUS, q, ql);
    if (!busy_end) `CHK("hold", last, n_int_out)
    if (!busy_end) `CHK("state", 2'h3, q[31:30])
  endtask
  task automatic t_ramps;
    host.wr(fmcw_pkg::REG_CLOCK, 32'h0000_0180);
    host.start(32'h0000_0C40, r0w(12'd100, 12'd0));
    repeat (30) @(posedge core_clk);
    #1 `CHK("no timer", 12'd100, n_int_out)
    host.wr(fmcw_pkg::REG_CLOCK, R4_RAMP);
    // Steps of one integer keep the integer rise well under 256
    t_ramp(2'h3, 1'b0, 3, '{1, 2, 3, 0, 0, 0, 0}, 1'b0);
    t_ramp(2'h2, 1'b0, 4, '{1, 2, 3, 0, 0, 0, 0}, 1'b0);
    t_ramp(2'h3, 1'b1, 6, '{1, 2, 3, 2, 1, 0, 0}, 1'b0);
    t_ramp(2'h0, 1'b0, 5, '{1, 2, 3, 0, 1, 0, 0}, 1'b1);
    t_ramp(2'h1, 1'b0, 7, '{1, 2, 3, 2, 1, 0, 1}, 1'b1);
    host.wr(fmcw_pkg::REG_FRAC_INT, r0w(12'd100, 12'd0));
    settle;
    `CHK("stopped", 1'b0, ramp_busy)
  endtask
  // Watchdog against a hang anywhere in the run
  initial begin
    #1000000;
    error_cnt++;
    print_verdict;
  end
  // Main sequence
  initial begin
    reset_n = 1'b0;
    modulation_input_pin = 1'b0;
    slip_pending = 1'b0;
    slip_dir_up = 1'b0;
    freq_passed = 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    t_init;
    t_ref;
    t_slip;
    t_psk;
    t_fsk;
    t_ramps;
    print_verdict;
  end
endmodule
